/* design/cicb_cfg.svh */
// Register offsets, field positions, reset values and codes for the interrupt code block
`ifndef CICB_CFG_SVH
`define CICB_CFG_SVH

`define CICB_OFF_IRQ_CODE 8'h00
`define CICB_OFF_BUF_BASE 8'h04
`define CICB_OFF_CONTROL 8'h08
`define CICB_OFF_FIFO_EN 8'h0C
`define CICB_OFF_MOD_EN 8'h10

`define CICB_FHIT_LSB 8
`define CICB_FHIT_MSB 12
`define CICB_CODE_MSB 6
`define CICB_OPERATING_MODE_SELECT_LSB 21
`define CICB_OPERATING_MODE_SELECT_MSB 23

`define CICB_OPERATING_MODE_SELECT_CONFIG 3'h4
`define CICB_OPERATING_MODE_SELECT_RESET 3'h4

`define CICB_CODE_NONE 7'h40
`define CICB_CODE_ERR 7'h41
`define CICB_CODE_WAKE 7'h42
`define CICB_CODE_OVF 7'h43
`define CICB_CODE_ADDR 7'h44
`define CICB_CODE_BW 7'h45
`define CICB_CODE_TMR 7'h46
`define CICB_CODE_MODE 7'h4F
`define CICB_CODE_INVAL 7'h48

`define CICB_BASE_RESET 32'h0000_0000
`define CICB_FHIT_RESET 5'h00
`define CICB_RESP_OKAY 2'h0
`define CICB_RESP_SLVERR 2'h2

`endif

/* design/cicb_code_enc.sv */
// Priority encoder from enabled pending sources to the 7-bit code
`include "cicb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cicb_code_enc #(
  parameter int NUM_FIFO = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Masked pending sources
  input wire logic [NUM_FIFO-1:0] fifo_pend,
  input wire cicb_pkg::cicb_mod_flags_t mod_pend,
  // Registered code
  output logic [6:0] code_r
);
  logic [6:0] code_nxt;

  // Refuse FIFO counts the 5-bit code space cannot name
  if (NUM_FIFO < 1 || NUM_FIFO > 32) begin : g_bad_num_fifo
    $error("NUM_FIFO must lie in 1..32");
  end

  // Lowest FIFO number wins, then module sources in fixed order
  always_comb begin
    code_nxt = `CICB_CODE_NONE;
    if (mod_pend.invalid_message_flag) code_nxt = `CICB_CODE_INVAL;
    if (mod_pend.mode_change_flag) code_nxt = `CICB_CODE_MODE;
    if (mod_pend.timestamp_timer_flag) code_nxt = `CICB_CODE_TMR;
    if (mod_pend.bandwidth_flag) code_nxt = `CICB_CODE_BW;
    if (mod_pend.system_error_flag) code_nxt = `CICB_CODE_ADDR;
    if (mod_pend.receive_overflow_flag) code_nxt = `CICB_CODE_OVF;
    if (mod_pend.wakeup_flag) code_nxt = `CICB_CODE_WAKE;
    if (mod_pend.bus_error_flag) code_nxt = `CICB_CODE_ERR;
    for (int i = NUM_FIFO - 1; i >= 0; i--) begin
      if (fifo_pend[i]) code_nxt = 7'(i);
    end
  end

  // Code register, idle value after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_r <= `CICB_CODE_NONE;
    end else begin
      code_r <= code_nxt;
    end
  end

  a_code_legal: assert property (@(posedge clk) disable iff (!rst_n)
    (code_r < 7'h20) || (code_r inside {[7'h40:7'h48], 7'h4F}))
    else $error("reserved interrupt code reported");
endmodule
`default_nettype wire

/* design/cicb_pkg.sv */
// Types shared by the interrupt code block
`default_nettype none
package cicb_pkg;
  // Module-level pending flags, in priority order from bit 0
  typedef struct packed {
    logic invalid_message_flag;
    logic mode_change_flag;
    logic timestamp_timer_flag;
    logic bandwidth_flag;
    logic system_error_flag;
    logic receive_overflow_flag;
    logic wakeup_flag;
    logic bus_error_flag;
  } cicb_mod_flags_t;

  typedef enum logic [1:0] {
    CICB_WR_IDLE,
    CICB_WR_RESP
  } cicb_wr_state_t;
endpackage
`default_nettype wire

/* design/cicb_top.sv */
// Interrupt code, filter hit and message buffer base registers over AXI4-Lite
//
// Local design decisions: the address map and the AXI4-Lite register port.
`include "cicb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cicb_top #(
  parameter int NUM_FIFO = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Pending flags from the CAN engine, same clock
  input wire logic [NUM_FIFO-1:0] fifo_interrupt_flags,
  input wire cicb_pkg::cicb_mod_flags_t mod_flags,
  // Filter match report from the acceptance logic
  input wire logic filter_match_valid,
  input wire logic [4:0] filter_match_index,
  // Buffer base towards the bus master, physical address
  output logic [31:0] message_buffer_base,
  output logic [2:0] operating_mode_select
);
  logic [31:0] base_r;
  logic [2:0] operating_mode_select_r;
  logic [NUM_FIFO-1:0] fifo_en_r;
  logic [7:0] mod_en_r;
  logic [4:0] fhit_r;
  logic [6:0] code_w;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [31:0] base_mask;
  cicb_pkg::cicb_wr_state_t wr_state_r;
  cicb_pkg::cicb_mod_flags_t mod_masked;

  // Refuse FIFO counts the 32-bit enable register cannot carry
  if (NUM_FIFO < 1 || NUM_FIFO > 32) begin : g_bad_num_fifo
    $error("NUM_FIFO must lie in 1..32");
  end

  // Disabled sources are masked before the encoder sees them
  assign mod_masked = mod_flags & mod_en_r;

  cicb_code_enc #(
    .NUM_FIFO(NUM_FIFO)
  ) u_enc (
    .clk(clk),
    .rst_n(rst_n),
    .fifo_pend(fifo_interrupt_flags & fifo_en_r),
    .mod_pend(mod_masked),
    .code_r(code_w)
  );

  // Filter hit capture; reads do not disturb it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fhit_r <= `CICB_FHIT_RESET;
    end else if (filter_match_valid) begin
      fhit_r <= filter_match_index;
    end
  end

  // Address and data may arrive in either order; each is latched once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  assign wr_fire = aw_held_r && w_held_r && (wr_state_r == cicb_pkg::CICB_WR_IDLE);
  assign wr_ok = awaddr_r[7:2] inside {`CICB_OFF_IRQ_CODE >> 2, `CICB_OFF_BUF_BASE >> 2,
    `CICB_OFF_CONTROL >> 2, `CICB_OFF_FIFO_EN >> 2, `CICB_OFF_MOD_EN >> 2};

  // Ready only while nothing of that channel is held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) &&
        (wr_state_r == cicb_pkg::CICB_WR_IDLE);
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) &&
        (wr_state_r == cicb_pkg::CICB_WR_IDLE);
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_state_r <= cicb_pkg::CICB_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CICB_RESP_OKAY;
    end else begin
      unique case (wr_state_r)
        cicb_pkg::CICB_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_r <= cicb_pkg::CICB_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `CICB_RESP_OKAY : `CICB_RESP_SLVERR;
          end
        end
        cicb_pkg::CICB_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= cicb_pkg::CICB_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_r <= cicb_pkg::CICB_WR_IDLE;
        end
      endcase
    end
  end

  // Byte-lane mask for the base register
  always_comb begin
    base_mask = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) base_mask[b*8 +: 8] = 8'hFF;
    end
  end

  // Base address; a write outside config mode is quietly dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_r <= `CICB_BASE_RESET;
    end else if (wr_fire && awaddr_r == `CICB_OFF_BUF_BASE &&
                 operating_mode_select_r == `CICB_OPERATING_MODE_SELECT_CONFIG) begin
      base_r <= ((base_r & ~base_mask) | (wdata_r & base_mask)) & 32'hFFFF_FFFC;
    end
  end

  // Control, FIFO enable and module enable registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operating_mode_select_r <= `CICB_OPERATING_MODE_SELECT_RESET;
      fifo_en_r <= '0;
      mod_en_r <= 8'h00;
    end else if (wr_fire) begin
      if (awaddr_r == `CICB_OFF_CONTROL && wstrb_r[2]) begin
        operating_mode_select_r <= wdata_r[`CICB_OPERATING_MODE_SELECT_MSB:`CICB_OPERATING_MODE_SELECT_LSB];
      end
      if (awaddr_r == `CICB_OFF_FIFO_EN) begin
        for (int b = 0; b < NUM_FIFO; b++) begin
          if (wstrb_r[b/8]) fifo_en_r[b] <= wdata_r[b];
        end
      end
      if (awaddr_r == `CICB_OFF_MOD_EN && wstrb_r[0]) begin
        mod_en_r <= wdata_r[7:0];
      end
    end
  end

  // Read mux; writes to the code register are accepted and ignored
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `CICB_OFF_IRQ_CODE: begin
        rd_word[`CICB_FHIT_MSB:`CICB_FHIT_LSB] = fhit_r;
        rd_word[`CICB_CODE_MSB:0] = code_w;
      end
      `CICB_OFF_BUF_BASE: rd_word = base_r;
      `CICB_OFF_CONTROL: rd_word[`CICB_OPERATING_MODE_SELECT_MSB:`CICB_OPERATING_MODE_SELECT_LSB] = operating_mode_select_r;
      `CICB_OFF_FIFO_EN: rd_word[NUM_FIFO-1:0] = fifo_en_r;
      `CICB_OFF_MOD_EN: rd_word[7:0] = mod_en_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel: accept, answer next cycle, hold until taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CICB_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `CICB_RESP_OKAY : `CICB_RESP_SLVERR;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Outputs to the DMA side straight from flip-flops; no translation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      message_buffer_base <= `CICB_BASE_RESET;
      operating_mode_select <= `CICB_OPERATING_MODE_SELECT_RESET;
    end else begin
      message_buffer_base <= base_r;
      operating_mode_select <= operating_mode_select_r;
    end
  end

  // Enables one cycle back, lined up with the encoder's register stage
  logic [NUM_FIFO-1:0] fifo_en_d_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_en_d_r <= '0;
    end else begin
      fifo_en_d_r <= fifo_en_r;
    end
  end

  a_base_align: assert property (@(posedge clk) disable iff (!rst_n)
    base_r[1:0] == 2'h0)
    else $error("base address not word aligned");
  a_base_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (operating_mode_select_r != `CICB_OPERATING_MODE_SELECT_CONFIG) |=> $stable(base_r))
    else $error("base changed outside configuration mode");
  a_base_out: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 message_buffer_base == $past(base_r))
    else $error("base output lags wrong");
  a_code_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (code_w < 7'h20) |-> fifo_en_d_r[code_w[4:0] % NUM_FIFO])
    else $error("disabled fifo reported");
  a_code_none: assert property (@(posedge clk) disable iff (!rst_n)
    ((fifo_interrupt_flags & fifo_en_r) == '0 && mod_masked == 8'h00)
    |=> code_w == `CICB_CODE_NONE)
    else $error("code not idle with nothing pending");
  a_code_err: assert property (@(posedge clk) disable iff (!rst_n)
    ((fifo_interrupt_flags & fifo_en_r) == '0 && mod_masked.bus_error_flag)
    |=> code_w == `CICB_CODE_ERR)
    else $error("error source code wrong");
  a_fifo_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (fifo_interrupt_flags[0] && fifo_en_r[0]) |=> code_w == 7'h00)
    else $error("fifo 0 not reported");
  a_fhit_take: assert property (@(posedge clk) disable iff (!rst_n)
    filter_match_valid |=> fhit_r == $past(filter_match_index))
    else $error("filter hit not captured");
  a_rd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == `CICB_OFF_IRQ_CODE)
    |-> (s_axi_rdata[31:13] == 19'h0 && !s_axi_rdata[7]))
    else $error("reserved code bits not zero");

  c_base_write: cover property (@(posedge clk) disable iff (!rst_n) $changed(base_r));
  c_code_fifo: cover property (@(posedge clk) disable iff (!rst_n) code_w == 7'h1F);
  c_code_mode: cover property (@(posedge clk) disable iff (!rst_n) code_w == `CICB_CODE_MODE);
  c_slverr: cover property (@(posedge clk) disable iff (!rst_n)
    s_axi_bvalid && s_axi_bresp == `CICB_RESP_SLVERR);
endmodule
`default_nettype wire

/* verif/can_irq_code_and_buffer_base_test.sv */
// Self-checking bench for the interrupt code and buffer base registers
`timescale 1ns/1ps
`default_nettype none
module can_irq_code_and_buffer_base_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, base;
  logic [1:0] bresp, rresp;
  logic [31:0] set_fifo = 32'h0, fifo_flags;
  logic [7:0] set_mod = 8'h00;
  cicb_pkg::cicb_mod_flags_t mod_flags;
  logic hit_req = 1'b0, hit_valid;
  logic [4:0] hit_idx = 5'h00, hit_index;
  logic [2:0] mode;
  int fails = 0;
  int n_tests = 0;
  // 250 MHz
  always #2 clk = ~clk;
  cicb_top u_cicb_top (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .fifo_interrupt_flags(fifo_flags), .mod_flags(mod_flags),
    .filter_match_valid(hit_valid), .filter_match_index(hit_index),
    .message_buffer_base(base), .operating_mode_select(mode));
  cicb_engine_model u_cicb_engine_model (.clk(clk), .rst_n(rst_n), .set_fifo(set_fifo),
    .set_mod(set_mod), .hit_req(hit_req), .hit_idx(hit_idx), .fifo_flags(fifo_flags),
    .mod_flags(mod_flags), .hit_valid(hit_valid), .hit_index(hit_index));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Readies are looked at on the falling edge, stable until the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] r;
    b_hit = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int t = 0; t < 100 && !b_hit; t++) begin
      @(negedge clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) bready <= 1'b0;
    end
    chk("bvalid seen", {31'h0, b_hit}, 32'h1);
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    logic ar_hit, r_hit;
    logic [31:0] d;
    logic [1:0] r;
    r_hit = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int t = 0; t < 100 && !r_hit; t++) begin
      @(negedge clk);
      ar_hit = arvalid && arready;
      r_hit = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) rready <= 1'b0;
    end
    chk("rvalid seen", {31'h0, r_hit}, 32'h1);
    chk(n, d, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask
  // Expected interrupt code word, reserved bits zero
  function automatic logic [31:0] vw(input logic [4:0] h, input logic [6:0] c);
    return {19'h0, h, 1'b0, c};
  endfunction
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reset();
    rc("code", 8'h00, vw(5'h00, 7'h40), 2'h0);
    rc("base", 8'h04, 32'h0, 2'h0);
    chk("mode port", {29'h0, mode}, 32'h4);
  endtask
  task automatic t_base();
    wr(8'h04, 32'hFFFFFFFF, 2'h0);
    rc("base", 8'h04, 32'hFFFFFFFC, 2'h0);
    settle();
    chk("base port", base, 32'hFFFFFFFC);
  endtask
  task automatic t_mode();
    wr(8'h08, 32'h0, 2'h0);
    settle();
    chk("mode port", {29'h0, mode}, 32'h0);
    wr(8'h04, 32'h12345678, 2'h0);
    rc("base locked", 8'h04, 32'hFFFFFFFC, 2'h0);
    wr(8'h08, 32'h00800000, 2'h0);
    rc("mode reg", 8'h08, 32'h00800000, 2'h0);
    wr(8'h04, 32'h12345679, 2'h0);
    rc("base open", 8'h04, 32'h12345678, 2'h0);
    settle();
    chk("base port", base, 32'h12345678);
    chk("mode port", {29'h0, mode}, 32'h4);
  endtask
  // Lowest pending FIFO wins, also over module sources
  task automatic t_fifo();
    wr(8'h0C, 32'hFFFFFFFF, 2'h0);
    wr(8'h10, 32'h000000FF, 2'h0);
    set_mod <= 8'hFF;
    for (int i = 0; i < 32; i++) begin
      set_fifo <= 32'hFFFFFFFF << i;
      settle();
      rc("fifo code", 8'h00, vw(5'h00, i[6:0]), 2'h0);
    end
  endtask
  task automatic t_mask();
    wr(8'h0C, 32'h80000000, 2'h0);
    set_fifo <= 32'h80000010;
    wr(8'h10, 32'h0, 2'h0);
    settle();
    rc("masked", 8'h00, vw(5'h00, 7'h1F), 2'h0);
    wr(8'h0C, 32'h0, 2'h0);
    settle();
    rc("all off", 8'h00, vw(5'h00, 7'h40), 2'h0);
  endtask
  task automatic t_mod();
    logic [6:0] tbl [8] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h4F, 7'h48};
    set_fifo <= 32'h0;
    wr(8'h10, 32'h000000FF, 2'h0);
    for (int k = 0; k < 8; k++) begin
      set_mod <= 8'hFF << k;
      settle();
      rc("mod code", 8'h00, vw(5'h00, tbl[k]), 2'h0);
    end
    set_mod <= 8'h00;
  endtask
  task automatic hit(input logic [4:0] i);
    @(posedge clk);
    hit_req <= 1'b1;
    hit_idx <= i;
    @(posedge clk);
    hit_req <= 1'b0;
    settle();
  endtask
  task automatic t_hit_ro();
    hit(5'h1F);
    rc("hit 31", 8'h00, vw(5'h1F, 7'h40), 2'h0);
    wr(8'h00, 32'hFFFFFFFF, 2'h0);
    rc("code ro", 8'h00, vw(5'h1F, 7'h40), 2'h0);
    hit(5'h00);
    rc("hit 0", 8'h00, vw(5'h00, 7'h40), 2'h0);
    wr(8'h20, 32'h1, 2'h2);
    rc("unmapped", 8'h20, 32'h0, 2'h2);
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_base();
    t_mode();
    t_fifo();
    t_mask();
    t_mod();
    t_hit_ro();
    give_verdict();
  end
endmodule
`default_nettype wire

/* verif/cicb_engine_model.sv */
// Behavioural CAN engine: pending flag levels and filter match reports
`timescale 1ns/1ps
`default_nettype none
module cicb_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic [31:0] set_fifo,
  input wire logic [7:0] set_mod,
  input wire logic hit_req,
  input wire logic [4:0] hit_idx,
  // Towards the block
  output logic [31:0] fifo_flags,
  output cicb_pkg::cicb_mod_flags_t mod_flags,
  output logic hit_valid,
  output logic [4:0] hit_index
);
  // Flags are levels held until the bench clears them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_flags <= 32'h0;
      mod_flags <= 8'h00;
    end else begin
      fifo_flags <= set_fifo;
      mod_flags <= set_mod;
    end
  end
  // Index is junk outside its pulse, so a sloppy capture shows up
  always_ff @(posedge clk) begin
    hit_valid <= rst_n & hit_req;
    hit_index <= hit_req ? hit_idx : ~hit_index;
  end
endmodule
`default_nettype wire
